/* File: shared/pef_pkg.sv */
// Constants, types and helpers for the peripheral event flag block
//
// Summary of operation
// - A serial-port event sets the serial-port event flag, which stays set until software or a warm reset clears it.
// - A timer A compare match in compare mode or a capture in capture mode sets the capture/compare flag.
// - Timer B reaching its period value sets the timer B match flag until software writes it to zero or a warm reset clears it.
// - Every peripheral event flag is set by its event regardless of any enable, mask or global interrupt enable.
// - Reset status flags let software tell power-on, brown-out, master-clear and watchdog resets apart.
// - The brown-out status flag starts undefined, software sets it, and a later zero means a brown-out.
// - With brown-out detection disabled the brown-out status flag carries no meaningful value.
// - The power-on status flag is cleared by power-on reset and set by software, one meaning none since.
package pef_pkg;

  // ----------------------------------------------------------------
  // Bus geometry
  // ----------------------------------------------------------------
  localparam int PEF_ADDR_W = 8;
  localparam int PEF_DATA_W = 8;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [PEF_ADDR_W-1:0] PEF_OFS_EVENT_FLAGS = 8'h0C;
  localparam logic [PEF_ADDR_W-1:0] PEF_OFS_POWER_CTRL  = 8'h8E;
  localparam logic [PEF_ADDR_W-1:0] PEF_OFS_IRQ_STATUS  = 8'hF0;
  localparam logic [PEF_ADDR_W-1:0] PEF_OFS_IRQ_MASK    = 8'hF1;
  localparam logic [PEF_ADDR_W-1:0] PEF_OFS_RESET_CAUSE = 8'hF2;

  // ----------------------------------------------------------------
  // Event flag layout
  // ----------------------------------------------------------------
  localparam int PEF_BIT_TIMER_A_OVF   = 0;
  localparam int PEF_BIT_TIMER_B_MATCH = 1;
  localparam int PEF_BIT_CAPCOMP       = 2;
  localparam int PEF_BIT_SERIAL_PORT   = 3;
  localparam int PEF_BIT_ADC_DONE      = 6;
  localparam logic [PEF_DATA_W-1:0] PEF_FLAGS_IMPL_MASK = 8'h4F;
  localparam logic [PEF_DATA_W-1:0] PEF_FLAGS_RESET     = 8'h00;
  localparam logic [PEF_DATA_W-1:0] PEF_MASK_RESET      = 8'h00;

  // ----------------------------------------------------------------
  // Power control layout
  // ----------------------------------------------------------------
  localparam int   PEF_BIT_BROWNOUT       = 0;
  localparam int   PEF_BIT_POWER_ON       = 1;
  localparam logic PEF_POWER_ON_RESET_VAL = 1'b0;
  // Power-up value is undefined in the device; this constant is arbitrary
  localparam logic PEF_BROWNOUT_RESET_VAL = 1'b0;

  // ----------------------------------------------------------------
  // Reset cause layout
  // ----------------------------------------------------------------
  localparam int PEF_CAUSE_W                = 3;
  localparam int PEF_BIT_CAUSE_MASTER_CLEAR = 0;
  localparam int PEF_BIT_CAUSE_WATCHDOG     = 1;
  localparam int PEF_BIT_CAUSE_BROWNOUT     = 2;
  localparam logic [PEF_CAUSE_W-1:0] PEF_CAUSE_RESET = 3'h0;

  // ----------------------------------------------------------------
  // Capture/compare unit modes
  // ----------------------------------------------------------------
  typedef enum logic [1:0]
  {
    PEF_CCP_OFF,
    PEF_CCP_CAPTURE,
    PEF_CCP_COMPARE,
    PEF_CCP_PWM
  } pef_ccp_mode_t;

  // Address match against one register offset
  function automatic logic pef_hit(input logic [PEF_ADDR_W-1:0] addr,
                                   input logic [PEF_ADDR_W-1:0] ofs);
    pef_hit = (addr == ofs);
  endfunction

endpackage

/* File: rtl/pef_sync.sv */
// Two-stage synchroniser for a vector of independent levels
`timescale 1ns/1ps
module pef_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             i_clock,
  input  wire logic             i_sys_rst,
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] stage_one;

  always_ff @(posedge i_clock or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      stage_one <= '0;
      o_sync    <= '0;
    end
    else
    begin
      stage_one <= i_async;
      o_sync    <= stage_one;
    end
  end
endmodule // pef_sync

/* File: rtl/pef_sticky.sv */
// Sticky flag vector where a set in the same cycle beats a clear
`timescale 1ns/1ps
module pef_sticky #(
  parameter int               WIDTH     = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input  wire logic             i_clock,
  input  wire logic             i_sys_rst,
  input  wire logic [WIDTH-1:0] i_set,
  input  wire logic [WIDTH-1:0] i_clear,
  output logic      [WIDTH-1:0] o_q
);
  always_ff @(posedge i_clock or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      o_q <= RESET_VAL;
    else
      o_q <= (o_q & ~i_clear) | i_set;
  end
endmodule // pef_sticky

/* File: rtl/pef_irq_flags.sv */
// Peripheral event flags, interrupt request and reset status registers
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/1ps
module pef_irq_flags (
  input  wire logic                           i_clock,
  input  wire logic                           i_sys_rst,
  // Register port
  input  wire logic [pef_pkg::PEF_ADDR_W-1:0] i_addr,
  input  wire logic [pef_pkg::PEF_DATA_W-1:0] i_wr_data,
  input  wire logic                           i_wr_strobe,
  input  wire logic                           i_rd_strobe,
  output logic      [pef_pkg::PEF_DATA_W-1:0] o_rd_data,
  // Peripheral events, same clock
  input  wire logic                           i_adc_done,
  input  wire logic                           i_serial_port_event,
  input  wire logic                           i_capcomp_capture,
  input  wire logic                           i_capcomp_compare,
  input  wire pef_pkg::pef_ccp_mode_t         i_capcomp_mode,
  input  wire logic                           i_timer_a_overflow,
  input  wire logic [7:0]                     i_timer_b_count,
  input  wire logic [7:0]                     i_timer_b_period,
  // Reset sources and strap, from pins
  input  wire logic                           i_brownout_detect_enable,
  input  wire logic                           i_brownout_rst,
  input  wire logic                           i_master_clear_rst,
  input  wire logic                           i_watchdog_rst,
  // Interrupt request
  output logic                                o_irq
);
  import pef_pkg::*;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Rising edge of a level against its previous sample
  function automatic logic pef_rise(input logic now_level,
                                    input logic prev_level);
    pef_rise = now_level & ~prev_level;
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisation
  // ----------------------------------------------------------------
  localparam int PIN_W          = 4;
  localparam int PIN_BROWNOUT_EN      = 0;
  localparam int PIN_BROWNOUT_RST     = 1;
  localparam int PIN_MASTER_CLEAR_RST = 2;
  localparam int PIN_WATCHDOG_RST     = 3;

  logic [PIN_W-1:0] pin_raw;
  logic [PIN_W-1:0] pin_sync;
  logic [PIN_W-1:0] pin_prev;

  assign pin_raw[PIN_BROWNOUT_EN]      = i_brownout_detect_enable;
  assign pin_raw[PIN_BROWNOUT_RST]     = i_brownout_rst;
  assign pin_raw[PIN_MASTER_CLEAR_RST] = i_master_clear_rst;
  assign pin_raw[PIN_WATCHDOG_RST]     = i_watchdog_rst;

  pef_sync #(
    .WIDTH (PIN_W)
  ) u_pin_sync (
    .i_clock   (i_clock),
    .i_sys_rst (i_sys_rst),
    .i_async   (pin_raw),
    .o_sync    (pin_sync)
  );

  // Previous synchronised level for edge detection
  always_ff @(posedge i_clock or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      pin_prev <= '0;
    else
      pin_prev <= pin_sync;
  end

  // ----------------------------------------------------------------
  // Warm reset events
  // ----------------------------------------------------------------
  logic brownout_detect_enable;
  logic brownout_event;
  logic master_clear_event;
  logic watchdog_event;
  logic any_warm_reset;

  assign brownout_detect_enable = pin_sync[PIN_BROWNOUT_EN];
  // Brown-out requests are ignored while detection is off
  assign brownout_event     = pef_rise(pin_sync[PIN_BROWNOUT_RST], pin_prev[PIN_BROWNOUT_RST])
                              & brownout_detect_enable;
  assign master_clear_event = pef_rise(pin_sync[PIN_MASTER_CLEAR_RST], pin_prev[PIN_MASTER_CLEAR_RST]);
  assign watchdog_event     = pef_rise(pin_sync[PIN_WATCHDOG_RST], pin_prev[PIN_WATCHDOG_RST]);
  assign any_warm_reset     = brownout_event | master_clear_event | watchdog_event;

  // ----------------------------------------------------------------
  // Timer B period match
  // ----------------------------------------------------------------
  logic timer_b_equal;
  logic timer_b_equal_prev;

  assign timer_b_equal = (i_timer_b_count == i_timer_b_period);

  // Match counts once on entry, not every cycle it persists
  always_ff @(posedge i_clock or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      timer_b_equal_prev <= 1'b0;
    else
      timer_b_equal_prev <= timer_b_equal;
  end

  // ----------------------------------------------------------------
  // Event collection
  // ----------------------------------------------------------------
  logic [PEF_DATA_W-1:0] event_vec;
  logic                  capcomp_event;

  // ----------------------------------------------------------------
  // Capture/compare event
  // ----------------------------------------------------------------
  // Off and PWM modes never raise the flag
  always_comb
  begin
    case (i_capcomp_mode)
      PEF_CCP_CAPTURE: capcomp_event = i_capcomp_capture;
      PEF_CCP_COMPARE: capcomp_event = i_capcomp_compare;
      default:         capcomp_event = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // Event vector
  // ----------------------------------------------------------------
  // No enable term gates any of these
  always_comb
  begin
    event_vec                        = '0;
    event_vec[PEF_BIT_TIMER_A_OVF]   = i_timer_a_overflow;
    event_vec[PEF_BIT_TIMER_B_MATCH] = pef_rise(timer_b_equal, timer_b_equal_prev);
    event_vec[PEF_BIT_CAPCOMP]       = capcomp_event;
    event_vec[PEF_BIT_SERIAL_PORT]   = i_serial_port_event;
    event_vec[PEF_BIT_ADC_DONE]      = i_adc_done;
  end

  // ----------------------------------------------------------------
  // Write decode
  // ----------------------------------------------------------------
  logic wr_flags;
  logic wr_power;
  logic wr_status;
  logic wr_mask;
  logic wr_cause;

  // One register selected per strobe
  always_comb
  begin
    wr_flags  = 1'b0;
    wr_power  = 1'b0;
    wr_status = 1'b0;
    wr_mask   = 1'b0;
    wr_cause  = 1'b0;
    if (!i_wr_strobe)
      wr_flags = 1'b0;
    else if (pef_hit(i_addr, PEF_OFS_EVENT_FLAGS))
      wr_flags = 1'b1;
    else if (pef_hit(i_addr, PEF_OFS_POWER_CTRL))
      wr_power = 1'b1;
    else if (pef_hit(i_addr, PEF_OFS_IRQ_STATUS))
      wr_status = 1'b1;
    else if (pef_hit(i_addr, PEF_OFS_IRQ_MASK))
      wr_mask = 1'b1;
    else if (pef_hit(i_addr, PEF_OFS_RESET_CAUSE))
      wr_cause = 1'b1;
  end

  // ----------------------------------------------------------------
  // Peripheral event flag register
  // ----------------------------------------------------------------
  logic [PEF_DATA_W-1:0] flags;
  logic [PEF_DATA_W-1:0] flags_set;
  logic [PEF_DATA_W-1:0] flags_clear;

  // Plain read/write: a written one sets, a written zero clears
  always_comb
  begin
    flags_set   = event_vec & PEF_FLAGS_IMPL_MASK;
    flags_clear = '0;
    if (wr_flags)
    begin
      flags_set   = flags_set | (i_wr_data & PEF_FLAGS_IMPL_MASK);
      flags_clear = ~i_wr_data & PEF_FLAGS_IMPL_MASK;
    end
    if (any_warm_reset)
      flags_clear = PEF_FLAGS_IMPL_MASK;
  end

  pef_sticky #(
    .WIDTH     (PEF_DATA_W),
    .RESET_VAL (PEF_FLAGS_RESET)
  ) u_flags (
    .i_clock   (i_clock),
    .i_sys_rst (i_sys_rst),
    .i_set     (flags_set),
    .i_clear   (flags_clear),
    .o_q       (flags)
  );

  // ----------------------------------------------------------------
  // Interrupt status and mask
  // ----------------------------------------------------------------
  logic [PEF_DATA_W-1:0] irq_status;
  logic [PEF_DATA_W-1:0] irq_status_clear;
  logic [PEF_DATA_W-1:0] irq_mask;

  assign irq_status_clear = wr_status ? (i_wr_data & PEF_FLAGS_IMPL_MASK) : '0;

  // Write one to clear; a same-cycle event keeps the bit
  pef_sticky #(
    .WIDTH     (PEF_DATA_W),
    .RESET_VAL (PEF_FLAGS_RESET)
  ) u_irq_status (
    .i_clock   (i_clock),
    .i_sys_rst (i_sys_rst),
    .i_set     (event_vec & PEF_FLAGS_IMPL_MASK),
    .i_clear   (irq_status_clear),
    .o_q       (irq_status)
  );

  // ----------------------------------------------------------------
  // Interrupt mask
  // ----------------------------------------------------------------
  always_ff @(posedge i_clock or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      irq_mask <= PEF_MASK_RESET;
    else if (wr_mask)
      irq_mask <= i_wr_data & PEF_FLAGS_IMPL_MASK;
  end

  // ----------------------------------------------------------------
  // Interrupt request
  // ----------------------------------------------------------------
  // Stale status raises the line one cycle after the mask bit is set
  always_ff @(posedge i_clock or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      o_irq <= 1'b0;
    else
      o_irq <= |(irq_status & irq_mask);
  end

  // ----------------------------------------------------------------
  // Power control register
  // ----------------------------------------------------------------
  logic power_on_status;
  logic brownout_status;

  // The system (power-on) reset or a software write of zero clears this bit
  always_ff @(posedge i_clock or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      power_on_status <= PEF_POWER_ON_RESET_VAL;
    else if (wr_power)
      power_on_status <= i_wr_data[PEF_BIT_POWER_ON];
  end

  // ----------------------------------------------------------------
  // Brown-out status
  // ----------------------------------------------------------------
  // Brown-out clears the bit; it beats a software write
  always_ff @(posedge i_clock or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      brownout_status <= PEF_BROWNOUT_RESET_VAL;
    else if (brownout_event)
      brownout_status <= 1'b0;
    else if (wr_power)
      brownout_status <= i_wr_data[PEF_BIT_BROWNOUT];
  end

  // ----------------------------------------------------------------
  // Reset cause register
  // ----------------------------------------------------------------
  logic [PEF_CAUSE_W-1:0] reset_cause;
  logic [PEF_CAUSE_W-1:0] cause_set;
  logic [PEF_CAUSE_W-1:0] cause_clear;

  always_comb
  begin
    cause_set                             = '0;
    cause_set[PEF_BIT_CAUSE_MASTER_CLEAR] = master_clear_event;
    cause_set[PEF_BIT_CAUSE_WATCHDOG]     = watchdog_event;
    cause_set[PEF_BIT_CAUSE_BROWNOUT]     = brownout_event;
    cause_clear                           = wr_cause ? i_wr_data[PEF_CAUSE_W-1:0] : '0;
  end

  pef_sticky #(
    .WIDTH     (PEF_CAUSE_W),
    .RESET_VAL (PEF_CAUSE_RESET)
  ) u_reset_cause (
    .i_clock   (i_clock),
    .i_sys_rst (i_sys_rst),
    .i_set     (cause_set),
    .i_clear   (cause_clear),
    .o_q       (reset_cause)
  );

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  logic [PEF_DATA_W-1:0] next_rd_data;

  // Idle cycles and unmapped addresses read zero
  always_comb
  begin
    next_rd_data = '0;
    if (!i_rd_strobe)
      next_rd_data = '0;
    else if (pef_hit(i_addr, PEF_OFS_EVENT_FLAGS))
      next_rd_data = flags & PEF_FLAGS_IMPL_MASK;
    else if (pef_hit(i_addr, PEF_OFS_POWER_CTRL))
    begin
      next_rd_data[PEF_BIT_POWER_ON] = power_on_status;
      next_rd_data[PEF_BIT_BROWNOUT] = brownout_status;
    end
    else if (pef_hit(i_addr, PEF_OFS_IRQ_STATUS))
      next_rd_data = irq_status;
    else if (pef_hit(i_addr, PEF_OFS_IRQ_MASK))
      next_rd_data = irq_mask;
    else if (pef_hit(i_addr, PEF_OFS_RESET_CAUSE))
      next_rd_data[PEF_CAUSE_W-1:0] = reset_cause;
  end

  // ----------------------------------------------------------------
  // Read data register
  // ----------------------------------------------------------------
  // Data stands only in the cycle after the strobe
  always_ff @(posedge i_clock or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      o_rd_data <= '0;
    else
      o_rd_data <= next_rd_data;
  end

endmodule // pef_irq_flags

/* File: bench/pef_irq_flags_asserts.sv */
// Checker for the peripheral event flag block ports
`timescale 1ns/1ps
module pef_irq_flags_asserts
  import pef_pkg::*;
(
  input wire logic                  i_clock,
  input wire logic                  i_sys_rst,
  input wire logic [PEF_ADDR_W-1:0] i_addr,
  input wire logic [PEF_DATA_W-1:0] i_wr_data,
  input wire logic                  i_wr_strobe,
  input wire logic                  i_rd_strobe,
  input wire logic [PEF_DATA_W-1:0] o_rd_data,
  input wire logic                  i_adc_done,
  input wire logic                  i_serial_port_event,
  input wire logic                  i_timer_a_overflow
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_sys_rst);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  property p_rd_idle;
    !$past(i_rd_strobe) |-> o_rd_data == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not zero outside read cycle");
  property p_unimpl;
    $past(i_rd_strobe) && $past(i_addr) == 8'h0C |-> (o_rd_data & 8'hB0) == 8'h00;
  endproperty
  a_unimpl: assert property (p_unimpl) else $error("unused flag bits read non-zero");
  property p_unmapped;
    $past(i_rd_strobe) && !($past(i_addr) inside {8'h0C, 8'h8E, 8'hF0, 8'hF1, 8'hF2}) |-> o_rd_data == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_adc;
    i_adc_done ##1 (i_rd_strobe && i_addr == 8'h0C) |=> o_rd_data[6];
  endproperty
  a_adc: assert property (p_adc) else $error("converter done flag not set");
  property p_ser;
    i_serial_port_event ##1 (i_rd_strobe && i_addr == 8'h0C) |=> o_rd_data[3];
  endproperty
  a_ser: assert property (p_ser) else $error("serial flag not set");
  property p_tma;
    i_timer_a_overflow ##1 (i_rd_strobe && i_addr == 8'h0C) |=> o_rd_data[0];
  endproperty
  a_tma: assert property (p_tma) else $error("overflow flag not set");
  property p_wr_all;
    (i_wr_strobe && i_addr == 8'h0C && i_wr_data == 8'hFF) ##1 (i_rd_strobe && i_addr == 8'h0C)
      |=> o_rd_data == 8'h4F;
  endproperty
  a_wr_all: assert property (p_wr_all) else $error("flag write-back wrong");
  property p_por_bit;
    (i_wr_strobe && i_addr == 8'h8E && i_wr_data[1]) ##1 (i_rd_strobe && i_addr == 8'h8E) |=> o_rd_data[1];
  endproperty
  a_por_bit: assert property (p_por_bit) else $error("power-on bit not kept");
endmodule // pef_irq_flags_asserts

bind pef_irq_flags pef_irq_flags_asserts chk_u (.i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_addr(i_addr),
  .i_wr_data(i_wr_data), .i_wr_strobe(i_wr_strobe), .i_rd_strobe(i_rd_strobe), .o_rd_data(o_rd_data),
  .i_adc_done(i_adc_done), .i_serial_port_event(i_serial_port_event), .i_timer_a_overflow(i_timer_a_overflow));

/* File: bench/testbench.sv */
// Self-checking bench for the peripheral event flag block
`timescale 1ns/1ps
module testbench;
  import pef_pkg::*;
  logic                  i_clock = 1'b0;
  logic                  i_sys_rst = 1'b1;
  logic [PEF_ADDR_W-1:0] i_addr = 8'h00;
  logic [PEF_DATA_W-1:0] i_wr_data = 8'h00;
  logic                  i_wr_strobe = 1'b0;
  logic                  i_rd_strobe = 1'b0;
  logic [PEF_DATA_W-1:0] o_rd_data;
  logic [7:0]            ev = 8'h00;
  logic [7:0]            i_timer_b_count;
  logic                  bo = 1'b0;
  logic                  mc = 1'b0;
  logic                  wd = 1'b0;
  logic                  bo_en = 1'b1;
  logic                  o_irq;
  int                    error_cnt = 0;
  int                    tests_run = 0;
  // Event vector: 0 ovf, 1 match, 2 capture, 3 compare, 4 serial, 5 adc, 7:6 mode
  localparam logic [7:0] EV[9] = '{8'h01, 8'h02, 8'h44, 8'h88, 8'h10, 8'h20, 8'hC4, 8'h08, 8'h48};
  localparam logic [7:0] FL[9] = '{8'h01, 8'h02, 8'h04, 8'h04, 8'h08, 8'h40, 8'h00, 8'h00, 8'h00};

  always #12.5 i_clock = ~i_clock;
  assign i_timer_b_count = ev[1] ? 8'h10 : 8'h00;

  pef_irq_flags dut_u (.i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_addr(i_addr), .i_wr_data(i_wr_data),
    .i_wr_strobe(i_wr_strobe), .i_rd_strobe(i_rd_strobe), .o_rd_data(o_rd_data), .i_adc_done(ev[5]),
    .i_serial_port_event(ev[4]), .i_capcomp_capture(ev[2]), .i_capcomp_compare(ev[3]),
    .i_capcomp_mode(pef_ccp_mode_t'(ev[7:6])), .i_timer_a_overflow(ev[0]), .i_timer_b_count(i_timer_b_count),
    .i_timer_b_period(8'h10), .i_brownout_detect_enable(bo_en), .i_brownout_rst(bo),
    .i_master_clear_rst(mc), .i_watchdog_rst(wd), .o_irq(o_irq));

  // ----------------------------------------------------------------
  // Bus and compare tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clock);
    i_wr_strobe <= 1'b1;
    i_addr <= a;
    i_wr_data <= d;
    @(posedge i_clock);
    i_wr_strobe <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_clock);
    i_rd_strobe <= 1'b1;
    i_addr <= a;
    @(posedge i_clock);
    i_rd_strobe <= 1'b0;
    #1 d = o_rd_data;
  endtask
  task automatic wr_rd(input logic [7:0] wa, input logic [7:0] wdat, input logic [7:0] ra, output logic [7:0] d);
    @(posedge i_clock);
    i_wr_strobe <= 1'b1;
    i_addr <= wa;
    i_wr_data <= wdat;
    @(posedge i_clock);
    i_wr_strobe <= 1'b0;
    i_rd_strobe <= 1'b1;
    i_addr <= ra;
    @(posedge i_clock);
    i_rd_strobe <= 1'b0;
    #1 d = o_rd_data;
  endtask
  task automatic ev_rd(input logic [7:0] v, input logic [7:0] a, output logic [7:0] d);
    @(posedge i_clock);
    ev <= v;
    @(posedge i_clock);
    ev <= 8'h00;
    i_rd_strobe <= 1'b1;
    i_addr <= a;
    @(posedge i_clock);
    i_rd_strobe <= 1'b0;
    #1 d = o_rd_data;
  endtask
  task automatic pulse(input logic [7:0] v);
    @(posedge i_clock);
    ev <= v;
    @(posedge i_clock);
    ev <= 8'h00;
  endtask
  task automatic pin(input int which);
    @(posedge i_clock);
    bo <= (which == 0);
    mc <= (which == 1);
    wd <= (which == 2);
    repeat (4) @(posedge i_clock);
    bo <= 1'b0;
    mc <= 1'b0;
    wd <= 1'b0;
    repeat (5) @(posedge i_clock);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge i_clock);
    #1;
  endtask
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    logic [7:0] d;
    repeat (5) @(posedge i_clock);
    i_sys_rst <= 1'b0;
    foreach (EV[k])
    begin
      rd(8'h0C, d); chk(d, 8'h00);
    end
    rd(8'h8E, d); chk(d, 8'h00);
    rd(8'hF1, d); chk(d, 8'h00);
    chk({7'h00, o_irq}, 8'h00);
    $display("reset values done");
    foreach (EV[k])
    begin
      ev_rd(EV[k], 8'h0C, d); chk(d, FL[k]);
      idle(2);
      chk({7'h00, o_irq}, 8'h00);
      wr(8'h0C, 8'h00);
      rd(8'h0C, d); chk(d, 8'h00);
    end
    $display("event rows done");
    rd(8'hF0, d); chk(d, 8'h4F);
    wr(8'hF0, 8'hFF);
    wr(8'hF1, 8'h40);
    idle(2); chk({7'h00, o_irq}, 8'h00);
    pulse(8'h20);
    idle(2); chk({7'h00, o_irq}, 8'h01);
    wr(8'hF0, 8'h40);
    idle(2); chk({7'h00, o_irq}, 8'h00);
    $display("interrupt done");
    wr_rd(8'h0C, 8'hFF, 8'h0C, d); chk(d, 8'h4F);
    rd(8'h33, d); chk(d, 8'h00);
    wr(8'h33, 8'hFF);
    wr(8'h0C, 8'h00);
    rd(8'h0C, d); chk(d, 8'h00);
    $display("register access done");
    wr_rd(8'h8E, 8'h03, 8'h8E, d); chk(d, 8'h03);
    pin(0);
    rd(8'h8E, d); chk(d, 8'h02);
    rd(8'hF2, d); chk(d, 8'h04);
    pin(1);
    rd(8'hF2, d); chk(d, 8'h05);
    pin(2);
    rd(8'hF2, d); chk(d, 8'h07);
    wr(8'hF2, 8'h07);
    wr(8'h8E, 8'h03);
    bo_en <= 1'b0;
    idle(4);
    pin(0);
    rd(8'h8E, d); chk(d, 8'h03);
    rd(8'hF2, d); chk(d, 8'h00);
    $display("reset status done");
    // Event and clearing write in one cycle: the event wins
    @(posedge i_clock);
    ev <= 8'h20;
    i_wr_strobe <= 1'b1;
    i_addr <= 8'h0C;
    i_wr_data <= 8'h00;
    @(posedge i_clock);
    ev <= 8'h00;
    i_wr_strobe <= 1'b0;
    rd(8'h0C, d); chk(d, 8'h40);
    // Mid-run reset returns every register to its reset value
    @(posedge i_clock);
    i_sys_rst <= 1'b1;
    repeat (2) @(posedge i_clock);
    i_sys_rst <= 1'b0;
    rd(8'h0C, d); chk(d, 8'h00);
    rd(8'h8E, d); chk(d, 8'h00);
    rd(8'hF1, d); chk(d, 8'h00);
    chk({7'h00, o_irq}, 8'h00);
    $display("awkward cases done");
    give_verdict();
  end

  // Run limit: a hang counts as a mismatch
  initial
  begin
    repeat (20000) @(posedge i_clock);
    error_cnt++;
    $display("TIMEOUT t=%0t run limit reached", $time);
    give_verdict();
  end
endmodule // testbench
